// file: src/ltxu_map.vh
// constants for the logic test / exclusive-or execution slice
// assumes an 8-bit core with a 256-byte register file inside the slice
`ifndef LTXU_MAP_VH
`define LTXU_MAP_VH
// register offsets (byte addresses)
`define LTXU_OFF_CTRL 12'h000
`define LTXU_OFF_INSN 12'h004
`define LTXU_OFF_FLAGS 12'h008
`define LTXU_OFF_STAT 12'h00C
`define LTXU_OFF_RESULT 12'h010
`define LTXU_OFF_RFADDR 12'h014
`define LTXU_OFF_RFDATA 12'h018
// control fields
`define LTXU_CTRL_GO 0
`define LTXU_STAT_BUSY 0
`define LTXU_STAT_DONE 1
`define LTXU_STAT_ILLEGAL 2
// flags byte layout (chosen here, core layout is elsewhere)
`define LTXU_FLAG_C 7
`define LTXU_FLAG_Z 6
`define LTXU_FLAG_S 5
`define LTXU_FLAG_V 4
`define LTXU_FLAG_D 3
`define LTXU_FLAG_H 2
`define LTXU_FLAGS_RESET 8'h00
// opcodes
`define LTXU_OP_TCM_BASE 8'h62
`define LTXU_OP_TM_BASE 8'h72
`define LTXU_OP_XOR_BASE 8'hB2
// byte and cycle counts
`define LTXU_BYTES_SHORT 2
`define LTXU_BYTES_LONG 3
`define LTXU_CYC_REG 4
`define LTXU_CYC_LONG 6
// working register bank base used by short r forms
`define LTXU_WORK_BASE 8'hC0
`endif

// file: src/ltxu_alu.v
// combinational logic unit for the two mask tests and exclusive-or
// assumes operands arrive already fetched; the caller latches outputs
`timescale 1ns/10ps
`default_nettype none
module ltxu_alu (
    // operation select: 0 complement test, 1 plain test, 2 xor
    input wire [1:0] op,
    // operands
    input wire [7:0] dst,
    input wire [7:0] src,
    // result and flags
    output reg [7:0] result,
    output wire zero,
    output wire sign,
    output wire write_back
);
    always @* begin
        case (op)
            2'h0: result = (~dst) & src;
            2'h1: result = dst & src;
            2'h2: result = dst ^ src;
            default: result = 8'h00;
        endcase
    end
    assign zero = (result == 8'h00);
    assign sign = result[7];
    assign write_back = (op == 2'h2);
endmodule // ltxu_alu
`default_nettype wire

// file: src/ltxu_unit.v
// execution slice for the mask tests and exclusive-or, with a local
// register file, an instruction latch and an AHB-Lite register port.
// assumes a single AHB-Lite master, word-wide single transfers only.
// Summary of operation
// - complement test: (not dst) and mask
// - zero means all masked bits are one
// - decode 62..66 lengths and cycle counts
// - plain test: dst and mask, no write
// - zero means all masked bits zero
// - decode 72..76 lengths and cycle counts
// - xor result written, source kept
// - decode B2..B6 lengths and cycle counts
// - zero flag set on zero result
// - sign flag copies result bit seven
// - overflow cleared; carry, decimal, half kept
`timescale 1ns/10ps
`default_nettype none
`include "ltxu_map.vh"
module ltxu_unit (
    // clock, reset, enable
    input wire hclk,
    input wire hresetn,
    input wire clk_en,
    // ahb-lite slave
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // execution status
    output reg busy,
    output reg done
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_IND = 3'h2;
    localparam ST_EXEC = 3'h3;
    localparam ST_WAIT = 3'h4;

    reg [7:0] rf [0:255];
    reg [7:0] insn_op;
    reg [7:0] insn_b1;
    reg [7:0] insn_b2;
    reg [7:0] flags;
    reg [7:0] result_q;
    reg [7:0] rf_addr;
    reg illegal;
    reg [2:0] state;
    reg [2:0] cyc_cnt;
    reg [7:0] dst_addr;
    reg [7:0] src_addr;
    reg [7:0] dst_val;
    reg [7:0] src_val;
    reg [11:0] a_addr;
    reg a_write;
    reg a_valid;

    // decode helpers, used by both the executor and status readback
    function [1:0] dec_class;
        input [7:0] op;
        begin
            case (op[7:4])
                4'h6: dec_class = 2'h0;
                4'h7: dec_class = 2'h1;
                4'hB: dec_class = 2'h2;
                default: dec_class = 2'h3;
            endcase
        end
    endfunction

    // form index: 0 r,r 1 r,Ir 2 R,R 3 R,IR 4 R,IM; 7 illegal
    function [2:0] dec_form;
        input [7:0] op;
        begin
            if (dec_class(op) == 2'h3 || op[3:0] < 4'h2 || op[3:0] > 4'h6) begin
                dec_form = 3'h7;
            end else begin
                dec_form = op[2:0] - 3'h2;
            end
        end
    endfunction

    function [2:0] dec_cycles;
        input [2:0] form;
        begin
            dec_cycles = (form == 3'h0) ? 3'd`LTXU_CYC_REG : 3'd`LTXU_CYC_LONG;
        end
    endfunction

    function [1:0] dec_bytes;
        input [2:0] form;
        begin
            dec_bytes = (form < 3'h2) ? 2'd`LTXU_BYTES_SHORT : 2'd`LTXU_BYTES_LONG;
        end
    endfunction

    // short forms reach the working bank through a four-bit register number
    function [7:0] work_reg;
        input [3:0] num;
        begin
            work_reg = `LTXU_WORK_BASE | {4'h0, num};
        end
    endfunction

    wire [1:0] cur_class = dec_class(insn_op);
    wire [2:0] cur_form = dec_form(insn_op);
    wire [7:0] alu_result;
    wire alu_zero;
    wire alu_sign;
    wire alu_wb;

    ltxu_alu u_alu (
        .op(cur_class),
        .dst(dst_val),
        .src(src_val),
        .result(alu_result),
        .zero(alu_zero),
        .sign(alu_sign),
        .write_back(alu_wb)
    );

    // ahb address phase capture
    wire ahb_go = hsel && hready && htrans[1];
    wire wr_data = a_valid && a_write;
    wire go_write = wr_data && (a_addr == `LTXU_OFF_CTRL) && hwdata[`LTXU_CTRL_GO];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_valid <= 1'b0;
            a_write <= 1'b0;
            a_addr <= 12'h000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (clk_en) begin
            if (hready) begin
                a_valid <= ahb_go;
                a_write <= hwrite;
                a_addr <= {haddr[11:2], 2'b00};
            end
        end
    end

    // read data is registered in the address phase so it stands in the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (clk_en && hready) begin
            if (ahb_go && !hwrite) begin
                case ({haddr[11:2], 2'b00})
                    `LTXU_OFF_INSN: hrdata <= {8'h00, insn_b2, insn_b1, insn_op};
                    `LTXU_OFF_FLAGS: hrdata <= {24'h000000, flags};
                    `LTXU_OFF_STAT: hrdata <= {27'h0, dec_bytes(dec_form(insn_op)),
                        illegal, done, busy};
                    `LTXU_OFF_RESULT: hrdata <= {24'h000000, result_q};
                    `LTXU_OFF_RFADDR: hrdata <= {24'h000000, rf_addr};
                    `LTXU_OFF_RFDATA: hrdata <= {24'h000000, rf[rf_addr]};
                    default: hrdata <= 32'h00000000;
                endcase
            end else begin
                hrdata <= 32'h00000000;
            end
        end
    end

    // software-visible registers and executor
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            insn_op <= 8'h00;
            insn_b1 <= 8'h00;
            insn_b2 <= 8'h00;
            flags <= `LTXU_FLAGS_RESET;
            result_q <= 8'h00;
            rf_addr <= 8'h00;
            illegal <= 1'b0;
            state <= ST_IDLE;
            cyc_cnt <= 3'h0;
            dst_addr <= 8'h00;
            src_addr <= 8'h00;
            dst_val <= 8'h00;
            src_val <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
        end else if (clk_en) begin
            if (wr_data && state == ST_IDLE) begin
                case (a_addr)
                    `LTXU_OFF_INSN: begin
                        insn_op <= hwdata[7:0];
                        insn_b1 <= hwdata[15:8];
                        insn_b2 <= hwdata[23:16];
                    end
                    `LTXU_OFF_FLAGS: flags <= hwdata[7:0];
                    `LTXU_OFF_RFADDR: rf_addr <= hwdata[7:0];
                    default: ;
                endcase
            end
            case (state)
                ST_IDLE: begin
                    if (go_write) begin
                        done <= 1'b0;
                        busy <= 1'b1;
                        illegal <= (cur_form == 3'h7);
                        cyc_cnt <= 3'h1;
                        state <= (cur_form == 3'h7) ? ST_WAIT : ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    cyc_cnt <= cyc_cnt + 3'h1;
                    // short forms: dst nibble high, src nibble low, working bank
                    if (cur_form < 3'h2) begin
                        dst_addr <= work_reg(insn_b1[7:4]);
                        src_addr <= work_reg(insn_b1[3:0]);
                        dst_val <= rf[work_reg(insn_b1[7:4])];
                        src_val <= rf[work_reg(insn_b1[3:0])];
                    end else if (cur_form == 3'h4) begin
                        // immediate: opc dst src
                        dst_addr <= insn_b1;
                        dst_val <= rf[insn_b1];
                        src_val <= insn_b2;
                    end else begin
                        // long register forms: opc src dst
                        dst_addr <= insn_b2;
                        src_addr <= insn_b1;
                        dst_val <= rf[insn_b2];
                        src_val <= rf[insn_b1];
                    end
                    state <= (cur_form == 3'h1 || cur_form == 3'h3) ? ST_IND : ST_EXEC;
                end
                ST_IND: begin
                    // source register holds the operand address
                    cyc_cnt <= cyc_cnt + 3'h1;
                    src_val <= rf[src_val];
                    state <= ST_EXEC;
                end
                ST_EXEC: begin
                    cyc_cnt <= cyc_cnt + 3'h1;
                    result_q <= alu_result;
                    flags[`LTXU_FLAG_Z] <= alu_zero;
                    flags[`LTXU_FLAG_S] <= alu_sign;
                    flags[`LTXU_FLAG_V] <= 1'b0;
                    state <= ST_WAIT;
                end
                ST_WAIT: begin
                    // pad to the documented cycle count so timing is exact
                    if (illegal || cyc_cnt >= dec_cycles(cur_form)) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        state <= ST_IDLE;
                    end else begin
                        cyc_cnt <= cyc_cnt + 3'h1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // register file port: bus write when idle, xor write-back otherwise
    always @(posedge hclk) begin
        if (clk_en) begin
            if (state == ST_EXEC && alu_wb) begin
                // only xor stores; tests leave operands
                rf[dst_addr] <= alu_result;
            end else if (wr_data && state == ST_IDLE && a_addr == `LTXU_OFF_RFDATA) begin
                rf[rf_addr] <= hwdata[7:0];
            end
        end
    end
endmodule // ltxu_unit
`default_nettype wire

// file: dv/ltxu_unit_sva.sv
// checker for the logic test / exclusive-or slice: bus answer and run lengths
// assumes it is bound into ltxu_unit and sees only that module's ports
`timescale 1ns/10ps
`default_nettype none
`include "ltxu_map.vh"
module ltxu_unit_chk (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // status
    input wire logic busy,
    input wire logic done
);
    logic ph_v;
    logic ph_w;
    logic [11:0] ph_a;
    logic [7:0] op_q;
    wire rd_ph = ph_v && !ph_w;
    wire wr_ph = ph_v && ph_w;
    wire hi_ok = op_q[7:4] == 4'h6 || op_q[7:4] == 4'h7 || op_q[7:4] == 4'hB;
    wire legal = hi_ok && op_q[3:0] >= 4'h2 && op_q[3:0] <= 4'h6;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_v <= 1'h0;
            op_q <= 8'h00;
        end else begin
            ph_v <= hsel && hready && htrans[1];
            ph_w <= hwrite;
            ph_a <= haddr;
            // opcode writes while busy are dropped by the slice, so mirror that
            if (wr_ph && ph_a == `LTXU_OFF_INSN && !busy) begin
                op_q <= hwdata[7:0];
            end
        end
    end
    default clocking dcb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_short; busy [*4] ##1 !busy; endsequence
    sequence s_long; busy [*6] ##1 !busy; endsequence
    chk_ready_high:
        assert property (hreadyout) else $error("hreadyout dropped");
    chk_resp_okay:
        assert property (!hresp) else $error("error response seen");
    chk_short_count:
        assert property ($rose(busy) && legal && op_q[3:0] == 4'h2 |-> s_short)
        else $error("short form run length wrong");
    chk_long_count:
        assert property ($rose(busy) && legal && op_q[3:0] != 4'h2 |-> s_long)
        else $error("long form run length wrong");
    chk_done_on_fall:
        assert property ($fell(busy) |-> done) else $error("done missing at finish");
    chk_go_starts:
        assert property (wr_ph && ph_a == `LTXU_OFF_CTRL && hwdata[0] && !busy |=> busy && !done)
        else $error("go did not start a run");
    chk_rdata_idle:
        assert property (!rd_ph |-> hrdata == 32'h00000000) else $error("read data outside phase");
    chk_stat_mirror:
        assert property (rd_ph && ph_a == `LTXU_OFF_STAT |-> hrdata[1:0] == {$past(done), $past(busy)})
        else $error("status bits differ from ports");
endmodule // ltxu_unit_chk
bind ltxu_unit ltxu_unit_chk chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .busy, .done);
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench for ltxu_unit: every opcode of the three operations
// assumes a zero-wait AHB-Lite slave with the bench as the only master
`timescale 1ns/10ps
`default_nettype none
`include "ltxu_map.vh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    wire [31:0] hrdata;
    wire hreadyout;
    wire hresp;
    wire busy;
    wire done;
    int error_cnt = 0;
    int n_checks = 0;
    logic [31:0] q;
    logic [7:0] dadr;
    // opcode, byte1, byte2, result, destination after
    logic [39:0] tbl [15] = '{40'h62010000C7, 40'h63010020C7, 40'h640100002B,
        40'h650100002B, 40'h660034142B, 40'h72010002C7, 40'h73010003C7, 40'h740100022B,
        40'h750100232B, 40'h760054002B, 40'hB20100C5C5, 40'hB30100E6E6, 40'hB401002929,
        40'hB501000A0A, 40'hB600545E5E};
    logic [15:0] rf_init [6] = '{16'hC0C7, 16'hC102, 16'hC212, 16'h002B, 16'h0102, 16'h0223};
    ltxu_unit dut_u (.hclk(hclk), .hresetn(hresetn), .clk_en(1'h1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .busy(busy), .done(done));
    initial begin
        hclk = 1'h0;
        forever #20 hclk = ~hclk;
    end
    task automatic final_report();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'h1 && n < 50);
        // a slave that never answers counts against the run
        if (n >= 50) error_cnt++;
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask
    task automatic run(input logic [7:0] op, b1, b2, input logic stray);
        int n;
        bus(1'h1, `LTXU_OFF_INSN, {8'h00, b2, b1, op});
        bus(1'h1, `LTXU_OFF_CTRL, 32'h00000001);
        // opcode write during the run must be dropped
        if (stray) bus(1'h1, `LTXU_OFF_INSN, 32'h00000076);
        n = 0;
        do begin
            bus(1'h0, `LTXU_OFF_STAT, 32'h00000000);
            n++;
        end while (q[`LTXU_STAT_DONE] !== 1'h1 && n < 40);
        `CHK(q[`LTXU_STAT_DONE], 1'h1)
        `CHK(done, 1'h1)
    endtask
    initial begin
        repeat (20000) @(posedge hclk);
        error_cnt++;
        final_report();
    end
    initial begin
        hresetn = 1'h0;
        hsel = 1'h0;
        haddr = 12'h000;
        htrans = 2'h0;
        hwrite = 1'h0;
        hwdata = 32'h00000000;
        repeat (16) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        bus(1'h0, `LTXU_OFF_FLAGS, 32'h00000000);
        `CHK(q[7:0], `LTXU_FLAGS_RESET)
        bus(1'h0, `LTXU_OFF_STAT, 32'h00000000);
        `CHK(q[1:0], 2'h0)
        bus(1'h1, 12'h020, 32'hFFFFFFFF);
        bus(1'h0, 12'h020, 32'h00000000);
        `CHK(q, 32'h00000000)
        foreach (rf_init[k]) begin
            bus(1'h1, `LTXU_OFF_RFADDR, {24'h000000, rf_init[k][15:8]});
            bus(1'h1, `LTXU_OFF_RFDATA, {24'h000000, rf_init[k][7:0]});
        end
        foreach (tbl[i]) begin
            bus(1'h1, `LTXU_OFF_FLAGS, 32'h0000009C);
            run(tbl[i][39:32], tbl[i][31:24], tbl[i][23:16], 1'h1);
            `CHK(q[4:3], (tbl[i][35:32] < 4'h4) ? 2'h2 : 2'h3)
            bus(1'h0, `LTXU_OFF_INSN, 32'h00000000);
            `CHK(q[7:0], tbl[i][39:32])
            bus(1'h0, `LTXU_OFF_RESULT, 32'h00000000);
            `CHK(q[7:0], tbl[i][15:8])
            bus(1'h0, `LTXU_OFF_FLAGS, 32'h00000000);
            `CHK(q[7:0], 8'h8C | {1'h0, tbl[i][15:8] == 8'h00, tbl[i][15], 5'h00})
            dadr = (tbl[i][35:32] < 4'h4) ? {4'hC, tbl[i][31:28]}
                : ((tbl[i][35:32] == 4'h6) ? tbl[i][31:24] : tbl[i][23:16]);
            bus(1'h1, `LTXU_OFF_RFADDR, {24'h000000, dadr});
            bus(1'h0, `LTXU_OFF_RFDATA, 32'h00000000);
            `CHK(q[7:0], tbl[i][7:0])
        end
        bus(1'h1, `LTXU_OFF_RFADDR, 32'h00000001);
        bus(1'h0, `LTXU_OFF_RFDATA, 32'h00000000);
        `CHK(q[7:0], 8'h02)
        bus(1'h1, `LTXU_OFF_FLAGS, 32'h0000009C);
        run(8'h00, 8'h00, 8'h00, 1'h0);
        `CHK(q[`LTXU_STAT_ILLEGAL], 1'h1)
        bus(1'h0, `LTXU_OFF_FLAGS, 32'h00000000);
        `CHK(q[7:0], 8'h9C)
        final_report();
    end
endmodule // tb_top
`default_nettype wire
